// ---- design/sedc_pkg.sv ----
// Types shared by the serial memory / DAC control block.
// Assumes nothing beyond a SystemVerilog compiler.
package sedc_pkg;
    typedef struct packed {
        logic [6:0]  op;
        logic        area;
        logic [7:0]  addr;
        logic [15:0] data;
    } sedc_frame_t;
    typedef logic [3:0][7:0] sedc_dac_t;
    typedef enum logic [1:0] {PL_ARMED, PL_WAIT_FALL, PL_RUN, PL_DONE} sedc_pl_t;
endpackage

// ---- design/sedc_regs.svh ----
// Constants of the serial memory / DAC control block.
// Assumes inclusion by bare name from the design files.
`ifndef SEDC_REGS_SVH
`define SEDC_REGS_SVH
`define SEDC_OP_READ      7'h54
`define SEDC_OP_WRITE     7'h52
`define SEDC_OP_PEN       7'h51
`define SEDC_OP_PDIS      7'h50
`define SEDC_OP_SLEEP     7'h56
`define SEDC_OP_WAKE      7'h53
`define SEDC_DAC_MID      8'h80
`define SEDC_DAC_LAST     8'h03
`define SEDC_CMD_EDGE     6'h07
`define SEDC_HDR_EDGE     6'h0F
`define SEDC_WR_EDGE      6'h1F
`define SEDC_CLK_MHZ      125
`define SEDC_PROG_TIME_US 7000
`define SEDC_PROG_CYC     (`SEDC_PROG_TIME_US * `SEDC_CLK_MHZ)
`endif

// ---- design/sedc_top.sv ----
// Serial nonvolatile memory with four DAC code slots: link decoder, executor, FIFO.
// Assumes all pins are asynchronous to clk; sys_rst stands for power-up.
//
// Behaviour
// - Preload loads channels 0 to 3 ascending.
// - Select rise with write-lock low, then fall, starts preload.
// - Preload ignores link, output stays off.
// - Program-enable after preload enables programming.
// - Power-down floats DAC outputs, DAC standby.
// - Pin low or sleep command powers down.
// - Sleep-exit returns to normal if pin high.
// - Power-down with select high: memory standby.
// - Power-up state follows pins.
// - DAC codes start at midscale.
// - Frame: opcode, address, two data bytes.
// - Decode read and write with 9-bit address.
// - Write busy starts after 32nd rise.
// - Busy drives output low, then high.
// - Status held until next bit; float.
// - Output driven only for data, status.
// - Read shifts msb first from 17th fall.
// - Sequential read wraps low address bits.
// - Start with programming disabled.
// - Sample on rise, change on fall.
// - Address map: 256 words, four DAC slots.
// - DAC write obeys write-lock; enable gates only the stored copy.
// - DAC read sets output, returns code.
`timescale 1ns/1ns
`include "sedc_regs.svh"

// ----------------------------------------------------------------
// FIFO
// ----------------------------------------------------------------
module sedc_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  buf_r [DEPTH];
    logic [AW:0]   cnt_r, cnt_nxt;
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic          push, pop;

    assign in_ready  = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data  = buf_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_nxt  = push ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
        rp_nxt  = pop ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            wp_r  <= '0;
            rp_r  <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
        end
        if (push)
            buf_r[wp_r] <= in_data;
    end
endmodule // sedc_fifo

// ----------------------------------------------------------------
// Top
// ----------------------------------------------------------------
module sedc_top #(
    parameter int PROG_CYCLES = `SEDC_PROG_CYC
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         chip_select_n,
    input  wire logic         serial_clock_in,
    input  wire logic         serial_data_in,
    input  wire logic         power_down_pin_n,
    input  wire logic         write_lock_n,
    output logic              serial_data_out,
    output logic              serial_data_oe,
    output sedc_pkg::sedc_dac_t dac_code,
    output logic              dac_hiz,
    output logic              dac_standby,
    output logic              mem_standby,
    output logic              prog_enabled,
    output logic              busy
);
    localparam int PW = $clog2(PROG_CYCLES + 1);

    // Nonvolatile arrays keep no reset: they model stored content
    logic [15:0] mem_r [256];
    logic [7:0]  nv_r  [4];

    logic [4:0]  s1_r, s2_r;
    logic [1:0]  s3_r;
    logic        cs_n, sk, di, pdn, wln;
    logic        sk_rise, sk_fall, cs_rise, cs_fall, lock_io;

    sedc_pkg::sedc_pl_t    pl_r, pl_nxt;
    logic [1:0]            ch_r, ch_nxt;
    logic [31:0]           shf_r, shf_nxt, nsh;
    logic [5:0]            cnt_r, cnt_nxt;
    logic                  rd_on_r, rd_on_nxt, area_r, area_nxt;
    logic [7:0]            ra_r, ra_nxt, ra_inc;
    logic [15:0]           word_r, word_nxt;
    logic [3:0]            oidx_r, oidx_nxt;
    logic                  do_r, do_nxt, doe_r, doe_nxt;
    logic                  stat_r, stat_nxt, sleep_r, sleep_nxt, pen_r, pen_nxt;
    logic [PW-1:0]         pc_r, pc_nxt;
    sedc_pkg::sedc_dac_t   dac_r, dac_nxt;
    sedc_pkg::sedc_frame_t push_frm, f;
    logic                  push, in_rdy, f_valid, f_pop;
    logic                  mem_we, nv_we, pdown;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        s1_r <= {write_lock_n, power_down_pin_n, serial_data_in, serial_clock_in, chip_select_n};
        s2_r <= s1_r;
        s3_r <= s2_r[1:0];
    end

    assign cs_n    = s2_r[0];
    assign sk      = s2_r[1];
    assign di      = s2_r[2];
    assign pdn     = s2_r[3];
    assign wln     = s2_r[4];
    assign lock_io = pl_r == sedc_pkg::PL_RUN;
    assign sk_rise = sk && !s3_r[1] && !cs_n && !lock_io;
    assign sk_fall = !sk && s3_r[1] && !cs_n && !lock_io;
    assign cs_rise = cs_n && !s3_r[0];
    assign cs_fall = !cs_n && s3_r[0];
    assign nsh     = {shf_r[30:0], di};
    assign ra_inc  = (area_r && ra_r >= `SEDC_DAC_LAST) ? 8'h00 : 8'(ra_r + 8'h01);

    // Busy covers a queued frame too, so status never flickers ready early
    assign busy    = pc_r != '0 || f_valid;
    assign f_pop   = f_valid && pc_r == '0;

    // Write frames queue here; only one can be accepted while busy refuses the rest
    sedc_fifo #(.W($bits(sedc_pkg::sedc_frame_t)), .DEPTH(8)) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (push),
        .in_ready  (in_rdy),
        .in_data   (push_frm),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f)
    );

    // ----------------------------------------------------------------
    // Link decoder, read shifter, executor, preload
    // ----------------------------------------------------------------
    always_comb begin
        pl_nxt    = pl_r;
        ch_nxt    = ch_r;
        shf_nxt   = shf_r;
        cnt_nxt   = cnt_r;
        rd_on_nxt = rd_on_r;
        area_nxt  = area_r;
        ra_nxt    = ra_r;
        word_nxt  = word_r;
        oidx_nxt  = oidx_r;
        do_nxt    = do_r;
        doe_nxt   = doe_r;
        stat_nxt  = stat_r;
        sleep_nxt = sleep_r;
        pen_nxt   = pen_r;
        pc_nxt    = (pc_r != '0) ? PW'(pc_r - 1'b1) : pc_r;
        dac_nxt   = dac_r;
        push      = 1'b0;
        push_frm  = nsh;
        mem_we    = 1'b0;
        nv_we     = 1'b0;
        if (cs_fall && !lock_io) begin
            cnt_nxt = '0;
        end
        if (cs_rise) begin
            rd_on_nxt = 1'b0;
            doe_nxt   = 1'b0;
            if (stat_r && !busy)
                stat_nxt = 1'b0;
        end
        if (sk_rise) begin
            shf_nxt = nsh;
            if (cnt_r != 6'h3F)
                cnt_nxt = cnt_r + 6'h01;
            if (stat_r && !busy)
                stat_nxt = 1'b0;
            if (cnt_r == `SEDC_CMD_EDGE && !busy) begin
                case (nsh[7:0])
                    {`SEDC_OP_PEN, 1'b1},
                    {`SEDC_OP_PDIS, 1'b0},
                    {`SEDC_OP_SLEEP, 1'b0},
                    {`SEDC_OP_WAKE, 1'b0}: begin
                        push     = 1'b1;
                        push_frm = {nsh[7:0], 24'h000000};
                    end
                    default: ;
                endcase
            end
            if (cnt_r == `SEDC_HDR_EDGE && nsh[15:9] == `SEDC_OP_READ && !busy) begin
                rd_on_nxt = 1'b1;
                area_nxt  = nsh[8];
                ra_nxt    = nsh[7:0];
                oidx_nxt  = '0;
                word_nxt  = !nsh[8] ? mem_r[nsh[7:0]] :
                            (nsh[7:0] <= `SEDC_DAC_LAST) ? {8'h00, nv_r[nsh[1:0]]} : 16'h0000;
                if (nsh[8] && nsh[7:0] <= `SEDC_DAC_LAST)
                    dac_nxt[nsh[1:0]] = nv_r[nsh[1:0]];
                if (pl_r != sedc_pkg::PL_RUN)
                    pl_nxt = sedc_pkg::PL_DONE;
            end
            if (cnt_r == `SEDC_WR_EDGE && nsh[31:25] == `SEDC_OP_WRITE && !busy) begin
                push     = in_rdy;
                stat_nxt = 1'b1;
            end
        end
        if (sk_fall && rd_on_r) begin
            do_nxt   = word_r[~oidx_r];
            doe_nxt  = 1'b1;
            oidx_nxt = oidx_r + 4'h1;
            if (oidx_r == 4'hF) begin
                ra_nxt   = ra_inc;
                word_nxt = area_r ? {8'h00, nv_r[ra_inc[1:0]]} : mem_r[ra_inc];
                if (area_r)
                    dac_nxt[ra_inc[1:0]] = nv_r[ra_inc[1:0]];
            end
        end
        if (f_pop) begin
            if (pl_r != sedc_pkg::PL_RUN)
                pl_nxt = sedc_pkg::PL_DONE;
            case (f.op)
                `SEDC_OP_PEN:   pen_nxt = 1'b1;
                `SEDC_OP_PDIS:  pen_nxt = 1'b0;
                `SEDC_OP_SLEEP: if (pdn) sleep_nxt = 1'b1;
                `SEDC_OP_WAKE:  if (pdn) sleep_nxt = 1'b0;
                `SEDC_OP_WRITE: begin
                    if (!f.area && pen_r) begin
                        mem_we = 1'b1;
                        pc_nxt = PW'(PROG_CYCLES);
                    end else if (f.area && f.addr <= `SEDC_DAC_LAST && wln) begin
                        dac_nxt[f.addr[1:0]] = f.data[7:0];
                        if (pen_r) begin
                            nv_we  = 1'b1;
                            pc_nxt = PW'(PROG_CYCLES);
                        end
                    end
                end
                default: ;
            endcase
        end
        case (pl_r)
            sedc_pkg::PL_ARMED:
                if (cs_rise)
                    pl_nxt = wln ? sedc_pkg::PL_DONE : sedc_pkg::PL_WAIT_FALL;
            sedc_pkg::PL_WAIT_FALL:
                if (cs_fall) begin
                    pl_nxt = sedc_pkg::PL_RUN;
                    ch_nxt = 2'h0;
                end
            sedc_pkg::PL_RUN: begin
                dac_nxt[ch_r] = nv_r[ch_r];
                ch_nxt        = ch_r + 2'h1;
                if (ch_r == 2'h3)
                    pl_nxt = sedc_pkg::PL_DONE;
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pl_r    <= sedc_pkg::PL_ARMED;
            ch_r    <= 2'h0;
            shf_r   <= 32'h00000000;
            cnt_r   <= 6'h3F;
            rd_on_r <= 1'b0;
            area_r  <= 1'b0;
            ra_r    <= 8'h00;
            word_r  <= 16'h0000;
            oidx_r  <= 4'h0;
            do_r    <= 1'b0;
            doe_r   <= 1'b0;
            stat_r  <= 1'b0;
            sleep_r <= 1'b0;
            pen_r   <= 1'b0;
            pc_r    <= '0;
            dac_r   <= {4{`SEDC_DAC_MID}};
        end else begin
            pl_r    <= pl_nxt;
            ch_r    <= ch_nxt;
            shf_r   <= shf_nxt;
            cnt_r   <= cnt_nxt;
            rd_on_r <= rd_on_nxt;
            area_r  <= area_nxt;
            ra_r    <= ra_nxt;
            word_r  <= word_nxt;
            oidx_r  <= oidx_nxt;
            do_r    <= do_nxt;
            doe_r   <= doe_nxt;
            stat_r  <= stat_nxt;
            sleep_r <= sleep_nxt;
            pen_r   <= pen_nxt;
            pc_r    <= pc_nxt;
            dac_r   <= dac_nxt;
        end
        if (mem_we)
            mem_r[f.addr] <= f.data;
        if (nv_we)
            nv_r[f.addr[1:0]] <= f.data[7:0];
    end

    // Power state is derived live from the pins and sleep_r, so power-up needs no strap
    assign pdown           = !pdn || sleep_r;
    assign dac_hiz         = pdown;
    assign dac_standby     = pdown;
    assign mem_standby     = pdown && cs_n;
    assign dac_code        = dac_r;
    assign prog_enabled    = pen_r;
    assign serial_data_out = stat_r ? !busy : do_r;
    assign serial_data_oe  = !lock_io && (stat_r || doe_r);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_pl_start;
        pl_r == sedc_pkg::PL_WAIT_FALL && cs_fall;
    endsequence
    sequence s_pl_walk;
        pl_r == sedc_pkg::PL_RUN && ch_r == 2'h0 ##1 ch_r == 2'h1 ##1 ch_r == 2'h2 ##1 ch_r == 2'h3;
    endsequence

    property p_preload_order;
        s_pl_start |=> s_pl_walk ##1 pl_r == sedc_pkg::PL_DONE;
    endproperty
    a_preload_order: assert property (p_preload_order) else $error("preload order wrong");

    property p_preload_load;
        pl_r == sedc_pkg::PL_RUN |=> dac_r[$past(ch_r)] == nv_r[$past(ch_r)];
    endproperty
    a_preload_load: assert property (p_preload_load) else $error("preload code not loaded");

    property p_preload_quiet;
        pl_r == sedc_pkg::PL_RUN |-> !serial_data_oe && !sk_rise;
    endproperty
    a_preload_quiet: assert property (p_preload_quiet) else $error("link active in preload");

    property p_pd_float;
        (!pdn || sleep_r) |-> dac_hiz && dac_standby;
    endproperty
    a_pd_float: assert property (p_pd_float) else $error("dac not floated");

    property p_deep_pd;
        dac_standby && cs_n |-> mem_standby;
    endproperty
    a_deep_pd: assert property (p_deep_pd) else $error("memory not in standby");

    property p_busy_low;
        stat_r && pc_r != '0 |-> serial_data_oe && !serial_data_out;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("busy not low");

    property p_write_busy;
        sk_rise && cnt_r == `SEDC_WR_EDGE && nsh[31:25] == `SEDC_OP_WRITE && !busy |=> stat_r && busy;
    endproperty
    a_write_busy: assert property (p_write_busy) else $error("write did not go busy");

    property p_read_msb;
        sk_fall && rd_on_r && oidx_r == 4'h0 |=> serial_data_oe && serial_data_out == $past(word_r[15]);
    endproperty
    a_read_msb: assert property (p_read_msb) else $error("read msb wrong");

    property p_dac_wrap;
        sk_fall && rd_on_r && oidx_r == 4'hF && area_r && ra_r == `SEDC_DAC_LAST |=> ra_r == 8'h00;
    endproperty
    a_dac_wrap: assert property (p_dac_wrap) else $error("dac area did not wrap");
endmodule // sedc_top

// ---- test/sedc_host_model.sv ----
// Host side of the four-wire link: drives select, link clock and data in, samples data out.
// Assumes clk is the block's 125 MHz clock; one link half period is 5 clk, 80 ns per bit.
`timescale 1ns/1ns
module sedc_host (
    input  wire logic clk,
    output logic      chip_select_n,
    output logic      serial_clock_in,
    output logic      serial_data_in,
    input  wire logic serial_data_out
);
    // Select starts low so a preload can be armed from power-up; link clock idles high
    initial begin
        chip_select_n   = 1'h0;
        serial_clock_in = 1'h1;
        serial_data_in  = 1'h0;
    end

    task automatic half();
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic sel();
        half();
        chip_select_n = 1'h0;
        half();
    endtask

    // Unused data line shows the inverse of its last bit, never a stale copy
    task automatic desel();
        chip_select_n  = 1'h1;
        serial_data_in = ~serial_data_in;
        repeat (6) half();
    endtask

    // Bits go out msb first; data out is taken at the rise, where it is steady
    task automatic xfer(input logic [47:0] bits, input int n, output logic [31:0] rd);
        rd = 32'h0;
        sel();
        for (int i = n - 1; i >= 0; i--) begin
            serial_clock_in = 1'h0;
            serial_data_in  = bits[i];
            half();
            serial_clock_in = 1'h1;
            rd = {rd[30:0], serial_data_out};
            half();
        end
    endtask
endmodule // sedc_host

// ---- test/sedc_top_tb_top.sv ----
// Self-checking bench of the serial memory / DAC control block, its FIFO reached through the top.
// Assumes sedc_pkg, sedc_regs.svh and the host model are compiled before this file.
`timescale 1ns/1ns
`include "sedc_regs.svh"
module sedc_top_tb_top;
    logic                clk, sys_rst, power_down_pin_n, write_lock_n;
    logic                chip_select_n, serial_clock_in, serial_data_in, serial_data_out, serial_data_oe;
    logic                dac_hiz, dac_standby, mem_standby, prog_enabled, busy;
    sedc_pkg::sedc_dac_t dac_code;
    logic [31:0]         rd;
    int                  n_fail, comparisons, cyc;

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // Short programming time, yet long enough that a short frame can be sent into it
    sedc_top #(.PROG_CYCLES(200)) u_dut (.clk(clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
        .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
        .power_down_pin_n(power_down_pin_n), .write_lock_n(write_lock_n), .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe), .dac_code(dac_code), .dac_hiz(dac_hiz), .dac_standby(dac_standby),
        .mem_standby(mem_standby), .prog_enabled(prog_enabled), .busy(busy));
    sedc_host u_host (.clk(clk), .chip_select_n(chip_select_n), .serial_clock_in(serial_clock_in),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wclk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic cmd(input logic [7:0] c);
        u_host.xfer({16'h0, c, 24'h0}, 32, rd);
        chk(serial_data_oe, 1'h0);
        u_host.desel();
    endtask

    task automatic wr(input logic a, input logic [7:0] ad, input logic [15:0] d, input logic bz);
        u_host.xfer({16'h0, `SEDC_OP_WRITE, a, ad, d}, 32, rd);
        wclk(4);
        chk(busy, bz);
        if (bz) begin
            chk({serial_data_oe, serial_data_out}, 2'h2);
            for (int i = 0; i < 300 && busy !== 1'h0; i++)
                wclk(1);
            chk({serial_data_oe, serial_data_out}, 2'h3);
        end
        u_host.desel();
        chk(serial_data_oe, 1'h0);
    endtask

    // Reads two words, so every read also crosses one address step
    task automatic rdw(input logic a, input logic [7:0] ad, input logic [31:0] exp);
        u_host.xfer({`SEDC_OP_READ, a, ad, 32'h0}, 48, rd);
        chk(rd, exp);
        u_host.desel();
        chk(serial_data_oe, 1'h0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset(input logic lock);
        write_lock_n = lock;
        if (chip_select_n === 1'h1)
            u_host.sel();
        sys_rst = 1'h1;
        wclk(8);
        sys_rst = 1'h0;
        wclk(4);
        chk(dac_code, {4{`SEDC_DAC_MID}});
        chk({prog_enabled, busy, serial_data_oe, dac_hiz}, 4'h0);
        $display("t_reset finished");
    endtask

    task automatic t_cmds();
        cmd({`SEDC_OP_PEN, 1'h0});
        chk(prog_enabled, 1'h0);
        cmd({`SEDC_OP_PEN, 1'h1});
        chk(prog_enabled, 1'h1);
        cmd({`SEDC_OP_PDIS, 1'h0});
        chk(prog_enabled, 1'h0);
        $display("t_cmds finished");
    endtask

    task automatic t_dac();
        cmd({`SEDC_OP_PEN, 1'h1});
        for (int k = 0; k < 4; k++) begin
            wr(1'h1, k[7:0], {8'h0, 8'h11 * (k[7:0] + 8'h1)}, 1'h1);
            chk(dac_code[k], 8'h11 * (k[7:0] + 8'h1));
        end
        cmd({`SEDC_OP_PDIS, 1'h0});
        wr(1'h1, 8'h1, 16'h005A, 1'h0);
        chk(dac_code[1], 8'h5A);
        rdw(1'h1, 8'h1, 32'h00220033);
        chk(dac_code[1], 8'h22);
        write_lock_n = 1'h0;
        wr(1'h1, 8'h2, 16'h0077, 1'h0);
        chk(dac_code[2], 8'h33);
        write_lock_n = 1'h1;
        // A frame cut after 24 bits must leave the channel alone
        u_host.xfer({24'h0, `SEDC_OP_WRITE, 1'h1, 8'h0, 8'h0}, 24, rd);
        u_host.desel();
        chk(dac_code[0], 8'h11);
        rdw(1'h1, 8'h3, 32'h00440011);
        $display("t_dac finished");
    endtask

    task automatic t_mem();
        cmd({`SEDC_OP_PEN, 1'h1});
        wr(1'h0, 8'hFF, 16'h1357, 1'h1);
        wr(1'h0, 8'h00, 16'h2468, 1'h1);
        cmd({`SEDC_OP_PDIS, 1'h0});
        wr(1'h0, 8'h00, 16'h1111, 1'h0);
        rdw(1'h0, 8'hFF, 32'h13572468);
        $display("t_mem finished");
    endtask

    task automatic t_power();
        power_down_pin_n = 1'h0;
        wclk(6);
        chk({dac_hiz, dac_standby, mem_standby}, 3'h7);
        u_host.sel();
        chk({dac_standby, mem_standby}, 2'h2);
        u_host.desel();
        power_down_pin_n = 1'h1;
        wclk(6);
        chk({dac_hiz, mem_standby}, 2'h0);
        cmd({`SEDC_OP_SLEEP, 1'h0});
        chk({dac_hiz, dac_standby}, 2'h3);
        power_down_pin_n = 1'h0;
        cmd({`SEDC_OP_WAKE, 1'h0});
        power_down_pin_n = 1'h1;
        wclk(6);
        chk(dac_hiz, 1'h1);
        cmd({`SEDC_OP_WAKE, 1'h0});
        chk(dac_hiz, 1'h0);
        $display("t_power finished");
    endtask

    task automatic t_preload();
        t_reset(1'h0);
        u_host.desel();
        u_host.sel();
        wclk(4);
        chk(dac_code, 32'h44332211);
        chk(serial_data_oe, 1'h0);
        u_host.desel();
        write_lock_n = 1'h1;
        cmd({`SEDC_OP_PEN, 1'h1});
        chk(prog_enabled, 1'h1);
        $display("t_preload finished");
    endtask

    // A write queued through the FIFO programs; a frame sent into that busy time is refused
    task automatic t_fifo();
        cmd({`SEDC_OP_PEN, 1'h1});
        u_host.xfer({16'h0, `SEDC_OP_WRITE, 1'h0, 8'h00, 16'hA5A5}, 32, rd);
        chk(busy, 1'h1);
        u_host.desel();
        chk({serial_data_oe, serial_data_out}, 2'h2);
        u_host.xfer({40'h0, `SEDC_OP_PDIS, 1'h0}, 8, rd);
        chk({serial_data_oe, serial_data_out}, 2'h2);
        u_host.desel();
        wclk(60);
        chk({busy, prog_enabled}, 2'h1);
        rdw(1'h0, 8'hFF, 32'h1357A5A5);
        $display("t_fifo finished");
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        sys_rst = 1'h1;
        power_down_pin_n = 1'h1;
        write_lock_n = 1'h1;
        t_reset(1'h1);
        u_host.desel();
        t_cmds();
        t_dac();
        t_mem();
        t_fifo();
        t_power();
        t_preload();
        test_done();
    end
endmodule // sedc_top_tb_top
